// file: common/bcim_pkg.sv
// Constants, types and the plain-words overview for the board configuration serial master
// Overview of operation
// RULE1: The block is only ever the bus master and starts every transfer itself, never answering another master.
// RULE2: Exactly two shared open-drain wires are used, one for the serial clock and one for serial data.
// RULE3: Up to seven populated slaves sit on the bus, each answering only its own distinct address.
// RULE4: A slave's three strap bits choose its address inside the upper-nibble-A window, from code 0 to code 7.
// RULE5: The board product record answers at code 0 and the user settings memory at code 1.
// RULE6: The planar presence record answers at code 4, mezzanine one at code 5 and mezzanine two at code 6.
// RULE7: The I/O module product record answers at code 2 and the temperature sensor at code 3.
// RULE8: Every memory slave holds 256 bytes, so one byte of word address selects a location.
// RULE9: Each fitted mezzanine carries its own presence record, separate from the planar one.
// RULE10: One planar presence record describes both planar banks, which must match in speed and size.
// RULE11: Some options are fixed from straps at power-up reset before any access; the rest are read over the bus.
// RULE12: The first byte of a transfer is the fixed upper pattern, the three address bits and the read flag; here it always carries the write flag.
package bcim_pkg;

  // Address byte layout
  localparam logic [3:0] ADDR_UPPER   = 4'ha;
  localparam logic       RW_WRITE     = 1'b0;
  localparam logic       RW_READ      = 1'b1;

  // Slave codes on the board
  localparam logic [2:0] DEV_PRODUCT  = 3'h0;
  localparam logic [2:0] DEV_USER     = 3'h1;
  localparam logic [2:0] DEV_IOMOD    = 3'h2;
  localparam logic [2:0] DEV_THERMO   = 3'h3;
  localparam logic [2:0] DEV_PLANAR   = 3'h4;
  localparam logic [2:0] DEV_MEZZ1    = 3'h5;
  localparam logic [2:0] DEV_MEZZ2    = 3'h6;

  // Transfer step indices
  localparam logic [1:0] STEP_ADDR    = 2'h0;
  localparam logic [1:0] STEP_WORD    = 2'h1;
  localparam logic [1:0] STEP_THIRD   = 2'h2;
  localparam logic [1:0] STEP_RDATA   = 2'h3;
  localparam logic [3:0] ACK_BIT      = 4'h8;

  // Serial clock timing: one bit is four quarters
  localparam int SCL_QUARTER_NS = 2500;
  localparam int LINK_PERIOD_PS = 32000;
  localparam int QUARTER_CYC    = (SCL_QUARTER_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);

  // Strap capture settles two synchroniser stages first
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Reset values
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [3:0] BITN_RESET   = 4'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} bcim_state_type;

endpackage

// file: common/bcim_xfer_if.sv
// Command and pin bundle between the system-side logic and the link engine
`timescale 1ns/1ps
`default_nettype none
interface bcim_xfer_if;
  logic       req_tgl;
  logic       ack_tgl;
  logic       write;
  logic [2:0] dev;
  logic [7:0] word;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       nack;
  logic       scl_oe;
  logic       sda_oe;

  modport sys  (output req_tgl, write, dev, word, wdata,
                input  ack_tgl, rdata, nack, scl_oe, sda_oe);
  modport link (input  req_tgl, write, dev, word, wdata,
                output ack_tgl, rdata, nack, scl_oe, sda_oe);
endinterface
`default_nettype wire

// file: hw/bcim_link_engine.sv
// Serial bit engine on the link clock: start, bytes, acknowledge, stop
`timescale 1ns/1ps
`default_nettype none
module bcim_link_engine #(
  parameter int QUARTER_CYCLES = bcim_pkg::QUARTER_CYC
) (
  // Link clock and reset
  input  wire logic i_link_clk,
  input  wire logic i_rst_n,
  // Data wire level from the pin
  input  wire logic i_sda_i,
  // Bundle to the system side
  bcim_xfer_if.link xf
);
  import bcim_pkg::*;

  // Last timer count of a quarter bit; a parameter so the bit rate can be changed
  localparam logic [6:0] QTR_LAST = 7'(QUARTER_CYCLES - 1);

  bcim_state_type state, next_state;
  logic [1:0] q, next_q;
  logic [6:0] tick;
  logic [3:0] bitn, next_bitn;
  logic [1:0] step, next_step;
  logic [7:0] shreg, next_shreg;
  logic [7:0] next_rdata;
  logic       ack_bad, next_ack_bad;
  logic       next_nack, next_ack_tgl, next_scl_oe, next_sda_oe;
  logic       req_s1, req_s2, req_seen, next_req_seen;
  logic       sda_s1, sda_s2;

  // Byte sent at each step; address byte is pattern, strap code, write flag, and a read's repeated one has the read flag
  function automatic logic [7:0] tx_byte(input logic [1:0] s, input logic wr,
                                         input logic [2:0] d, input logic [7:0] w,
                                         input logic [7:0] wd);
    if (s == STEP_ADDR)
      tx_byte = {ADDR_UPPER, d, RW_WRITE};               // see RULE12 see RULE4
    else if (s == STEP_WORD)
      tx_byte = w;                                        // see RULE8
    else if (s == STEP_THIRD)
      tx_byte = wr ? wd : {ADDR_UPPER, d, RW_READ};       // see RULE12
    else
      tx_byte = 8'hff;
  endfunction

  wire       quarter_end = (tick == QTR_LAST);
  wire       req_new     = req_s2 ^ req_seen;
  wire       rx_byte     = !xf.write && (step == STEP_RDATA);
  wire       last_byte   = (xf.write && step == STEP_THIRD) || (step == STEP_RDATA);
  wire       restart     = !xf.write && (step == STEP_WORD);
  wire [1:0] step_inc    = 2'(step + 2'h1);
  wire [7:0] load_byte   = tx_byte(step_inc, xf.write, xf.dev, xf.word, xf.wdata);
  wire       load_rx     = !xf.write && (step_inc == STEP_RDATA);

  // Sequencer; every transfer is started by this master alone
  always_comb begin
    next_state    = state;
    next_q        = q;
    next_bitn     = bitn;
    next_step     = step;
    next_shreg    = shreg;
    next_rdata    = xf.rdata;
    next_ack_bad  = ack_bad;
    next_nack     = xf.nack;
    next_ack_tgl  = xf.ack_tgl;
    next_scl_oe   = xf.scl_oe;
    next_sda_oe   = xf.sda_oe;
    next_req_seen = req_seen;
    case (state)
      ST_IDLE: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        if (req_new) begin                                // see RULE1
          next_req_seen = req_s2;
          next_state    = ST_START;
          next_q        = 2'h0;
          next_step     = STEP_ADDR;
          next_nack     = 1'b0;
        end
      end
      ST_START: if (quarter_end) begin
        next_q = 2'(q + 2'h1);
        case (q)
          2'h0: next_sda_oe = 1'b0;
          2'h1: next_scl_oe = 1'b0;
          2'h2: next_sda_oe = 1'b1;                       // Data falls while clock high
          default: begin
            // Clock falls alone; the first bit goes out a quarter later, so data
            // never moves in the same step as the falling clock
            next_scl_oe = 1'b1;
            next_state  = ST_BIT;
            next_q      = 2'h3;
            next_bitn   = 4'(BITN_RESET - 4'h1);
            next_shreg  = tx_byte(step, xf.write, xf.dev, xf.word, xf.wdata);
          end
        endcase
      end
      ST_BIT: if (quarter_end) begin
        next_q = 2'(q + 2'h1);
        case (q)
          2'h0: next_scl_oe = 1'b0;
          2'h1: begin
            if (bitn == ACK_BIT)
              next_ack_bad = sda_s2;
            else
              next_shreg = {shreg[6:0], sda_s2};
          end
          2'h2: next_scl_oe = 1'b1;
          default: begin
            if (bitn != ACK_BIT) begin
              next_bitn   = 4'(bitn + 4'h1);
              // Released for our acknowledge slot, read bits and the final NACK
              next_sda_oe = (next_bitn == ACK_BIT || rx_byte) ? 1'b0 : ~shreg[7];
            end else if (!rx_byte && ack_bad) begin
              next_nack   = 1'b1;                         // see RULE3
              next_state  = ST_STOP;
              next_sda_oe = 1'b1;
            end else if (last_byte) begin
              if (rx_byte)
                next_rdata = shreg;
              next_state  = ST_STOP;
              next_sda_oe = 1'b1;
            end else if (restart) begin
              next_state  = ST_START;
              next_step   = STEP_THIRD;
            end else begin
              next_step   = step_inc;
              next_bitn   = BITN_RESET;
              next_shreg  = load_byte;
              next_sda_oe = load_rx ? 1'b0 : ~load_byte[7];
            end
          end
        endcase
      end
      default: if (quarter_end) begin
        next_q = 2'(q + 2'h1);
        case (q)
          2'h0: next_sda_oe = 1'b1;
          2'h1: next_scl_oe = 1'b0;
          2'h2: next_sda_oe = 1'b0;                       // Data rises while clock high
          default: begin
            next_state   = ST_IDLE;
            next_ack_tgl = ~xf.ack_tgl;
          end
        endcase
      end
    endcase
  end

  // Request toggle and data wire synchronisers
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      req_s1 <= xf.req_tgl;
      req_s2 <= req_s1;
      sda_s1 <= i_sda_i;
      sda_s2 <= sda_s1;
    end
  end

  // Quarter-bit timer, idle at zero
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      tick <= 7'h00;
    else if (state == ST_IDLE || quarter_end)
      tick <= 7'h00;
    else
      tick <= 7'(tick + 7'h01);
  end

  // Sequencer state; pin enables high means pulling the wire low
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= ST_IDLE;
      q          <= 2'h0;
      bitn       <= BITN_RESET;
      step       <= STEP_ADDR;
      shreg      <= BYTE_RESET;
      ack_bad    <= 1'b0;
      req_seen   <= 1'b0;
      xf.rdata   <= BYTE_RESET;
      xf.nack    <= 1'b0;
      xf.ack_tgl <= 1'b0;
      xf.scl_oe  <= 1'b0;
      xf.sda_oe  <= 1'b0;
    end else begin
      state      <= next_state;
      q          <= next_q;
      bitn       <= next_bitn;
      step       <= next_step;
      shreg      <= next_shreg;
      ack_bad    <= next_ack_bad;
      req_seen   <= next_req_seen;
      xf.rdata   <= next_rdata;
      xf.nack    <= next_nack;
      xf.ack_tgl <= next_ack_tgl;
      xf.scl_oe  <= next_scl_oe;                          // see RULE2
      xf.sda_oe  <= next_sda_oe;                          // see RULE2
    end
  end
endmodule
`default_nettype wire

// file: hw/board_config_i2c_master.sv
// Top of the board configuration serial master: command port, straps, link engine
`timescale 1ns/1ps
`default_nettype none
module board_config_i2c_master #(
  parameter int STRAP_W        = 4,
  parameter int QUARTER_CYCLES = bcim_pkg::QUARTER_CYC
) (
  // System clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // Link clock for the bit engine
  input  wire logic               i_link_clk,
  // Command request
  input  wire logic               i_cmd_valid,
  input  wire logic               i_cmd_write,
  input  wire logic [2:0]         i_cmd_dev,
  input  wire logic [7:0]         i_cmd_word,
  input  wire logic [7:0]         i_cmd_wdata,
  output logic                    o_cmd_ready,
  // Command answer
  output logic                    o_rsp_valid,
  output logic [7:0]              o_rsp_rdata,
  output logic                    o_rsp_nack,
  // Planar presence byte, shared by both planar banks
  output logic [7:0]              o_planar_info,
  output logic                    o_planar_info_valid,
  // Power-up straps
  input  wire logic [STRAP_W-1:0] i_boot_strap,
  output logic [STRAP_W-1:0]      o_boot_cfg,
  output logic                    o_boot_cfg_valid,
  // Serial pins, open drain
  output logic                    o_scl_o,
  output logic                    o_scl_oe,
  input  wire logic               i_sda_i,
  output logic                    o_sda_o,
  output logic                    o_sda_oe
);
  import bcim_pkg::*;

  bcim_xfer_if xf ();

  logic [STRAP_W-1:0] strap_s1, strap_s2;
  logic [1:0]         settle;
  logic               ack_s1, ack_s2, ack_s3;
  logic               busy;
  logic               req_tgl, c_write;
  logic [2:0]         c_dev;
  logic [7:0]         c_word, c_wdata;
  logic               scl_s1, scl_s2, sda_s1, sda_s2;

  wire accept   = i_cmd_valid && o_cmd_ready;
  wire ack_edge = ack_s2 ^ ack_s3;
  wire planar   = !c_write && (c_dev == DEV_PLANAR);

  // Held command fields stay still while the engine works on them
  assign xf.req_tgl = req_tgl;
  assign xf.write   = c_write;
  assign xf.dev     = c_dev;
  assign xf.word    = c_word;
  assign xf.wdata   = c_wdata;

  bcim_link_engine #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_engine (
    .i_link_clk (i_link_clk),
    .i_rst_n    (i_rst_n),
    .i_sda_i    (i_sda_i),
    .xf         (xf.link)
  );

  // Strap synchroniser and capture after reset release
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      settle   <= 2'h0;
    end else begin
      strap_s1 <= i_boot_strap;
      strap_s2 <= strap_s1;
      if (settle != STRAP_SETTLE)
        settle <= 2'(settle + 2'h1);
    end
  end

  // Strap values freeze once, before the command port opens
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_boot_cfg       <= '0;
      o_boot_cfg_valid <= 1'b0;
    end else if (!o_boot_cfg_valid && settle == STRAP_SETTLE) begin
      o_boot_cfg       <= strap_s2;                       // see RULE11
      o_boot_cfg_valid <= 1'b1;
    end
  end

  // Acknowledge toggle crossing back from the link clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= xf.ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // Command capture; one transfer in flight, no queue
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_tgl <= 1'b0;
      c_write <= 1'b0;
      c_dev   <= DEV_PRODUCT;
      c_word  <= BYTE_RESET;
      c_wdata <= BYTE_RESET;
    end else if (accept) begin
      req_tgl <= ~req_tgl;                                // see RULE1
      c_write <= i_cmd_write;
      c_dev   <= i_cmd_dev;                               // see RULE3
      c_word  <= i_cmd_word;                              // see RULE8
      c_wdata <= i_cmd_wdata;
    end
  end

  // Busy spans request to acknowledge; ready waits for the straps
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy        <= 1'b0;
      o_cmd_ready <= 1'b0;
    end else begin
      busy        <= accept ? 1'b1 : (ack_edge ? 1'b0 : busy);
      o_cmd_ready <= o_boot_cfg_valid && !busy && !accept && !ack_edge;   // see RULE11
    end
  end

  // Answer pulse with the engine's result
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= BYTE_RESET;
      o_rsp_nack  <= 1'b0;
    end else begin
      o_rsp_valid <= ack_edge;
      if (ack_edge) begin
        o_rsp_rdata <= xf.rdata;
        o_rsp_nack  <= xf.nack;
      end
    end
  end

  // One planar record serves both banks, so a single byte covers them
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_planar_info       <= BYTE_RESET;
      o_planar_info_valid <= 1'b0;
    end else if (ack_edge && planar && !xf.nack) begin
      o_planar_info       <= xf.rdata;                    // see RULE10
      o_planar_info_valid <= 1'b1;
    end
  end

  // Pin drivers retimed onto the system clock; the output value is always low
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s1   <= 1'b0;
      scl_s2   <= 1'b0;
      sda_s1   <= 1'b0;
      sda_s2   <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
    end else begin
      scl_s1   <= xf.scl_oe;
      scl_s2   <= scl_s1;
      sda_s1   <= xf.sda_oe;
      sda_s2   <= sda_s1;
      o_scl_oe <= scl_s2;                                 // see RULE2
      o_sda_oe <= sda_s2;                                 // see RULE2
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verification/bcim_master_checker.sv
// Port-level timing checks for the board configuration serial master
`timescale 1ns/1ps
`default_nettype none
module bcim_master_checker #(
  parameter int STRAP_W        = 4,
  parameter int QUARTER_CYCLES = bcim_pkg::QUARTER_CYC
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // Command and answer
  input  wire logic               i_cmd_valid,
  input  wire logic               o_cmd_ready,
  input  wire logic               o_rsp_valid,
  input  wire logic [7:0]         o_rsp_rdata,
  input  wire logic               o_rsp_nack,
  input  wire logic [7:0]         o_planar_info,
  // Straps and pins
  input  wire logic [STRAP_W-1:0] o_boot_cfg,
  input  wire logic               o_boot_cfg_valid,
  input  wire logic               o_scl_o,
  input  wire logic               o_scl_oe,
  input  wire logic               o_sda_o,
  input  wire logic               o_sda_oe
);
  // Everything here lives on the system clock and rests during reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_take_drops_ready: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
    else $error("ready stayed high after a command was taken");
  // The start edge comes three quarter bits after a take; eight system cycles per
  // link cycle, plus slack for both crossings
  localparam int START_LIMIT = (3 * QUARTER_CYCLES + 4) * 8 + 16;
  logic [11:0] start_wait;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      start_wait <= 12'h000;
    else if (i_cmd_valid && o_cmd_ready)
      start_wait <= 12'h001;
    else if (o_sda_oe)
      start_wait <= 12'h000;
    else if (start_wait != 12'h000)
      start_wait <= 12'(start_wait + 12'h001);
  end
  a_take_starts_bus: assert property (start_wait <= 12'(START_LIMIT))
    else $error("no bus activity after a command was taken");
  a_ready_after_rsp: assert property (o_rsp_valid |=> o_cmd_ready && !o_rsp_valid)
    else $error("answer not a single pulse followed by ready");
  a_pins_open_drain: assert property (!o_scl_o && !o_sda_o)
    else $error("a serial pin drives a high level");
  a_idle_bus_free: assert property (o_cmd_ready |-> !o_scl_oe && !o_sda_oe)
    else $error("bus held while no transfer runs");
  a_nack_keeps_rdata: assert property (o_rsp_valid && o_rsp_nack |-> $stable(o_rsp_rdata))
    else $error("read byte changed on a refused transfer");
  a_rdata_holds: assert property (!o_rsp_valid |-> $stable(o_rsp_rdata))
    else $error("read byte moved outside an answer");
  a_planar_from_read: assert property ($changed(o_planar_info) |-> !o_rsp_nack &&
                                       (o_rsp_valid || $past(o_rsp_valid)))
    else $error("planar byte changed without a good answer");
  a_boot_frozen: assert property (o_boot_cfg_valid && $past(o_boot_cfg_valid) |->
                                  $stable(o_boot_cfg))
    else $error("frozen strap options changed");
  a_cfg_before_ready: assert property (o_cmd_ready |-> o_boot_cfg_valid)
    else $error("command port ready before straps were captured");
endmodule

bind board_config_i2c_master bcim_master_checker #(.STRAP_W(STRAP_W),
  .QUARTER_CYCLES(QUARTER_CYCLES)) u_checker (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
  .o_rsp_nack(o_rsp_nack), .o_planar_info(o_planar_info), .o_boot_cfg(o_boot_cfg),
  .o_boot_cfg_valid(o_boot_cfg_valid), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe));
`default_nettype wire

// file: verification/bcim_eeprom_model.sv
// Behavioural model of the seven 256x8 slaves sharing the serial bus
`timescale 1ns/1ps
`default_nettype none
module bcim_eeprom_model (
  // Wire levels on the bus
  input  wire logic i_scl,
  input  wire logic i_sda,
  // High pulls the data wire low
  output logic      o_sda_oe
);
  logic [7:0] mem [8][256];  // One separate memory per code
  logic [7:0] ptr [8];
  logic       restart;
  int         lag;           // Reply delay after SCL falls, ns

  // Fill every slave with a pattern the bench can predict
  initial begin
    o_sda_oe = 1'b0;
    restart = 1'b0;
    lag = 0;
    for (int d = 0; d < 8; d++) begin
      ptr[d] = 8'h00;
      for (int a = 0; a < 256; a++) begin
        mem[d][a] = 8'(a) ^ {3'(d), 3'(d), 2'h1};
      end
    end
  end

  // Data only moves while SCL is low, so start and stop stay unambiguous
  task automatic put(input logic v);
    @(negedge i_scl);
    #(lag) o_sda_oe = v;
  endtask

  task automatic get_byte(output logic [7:0] b);
    repeat (8) begin
      @(posedge i_scl);
      b = {b[6:0], i_sda};
    end
  endtask

  // One frame: address byte, then word and data or the read byte
  task automatic frame();
    logic [7:0] b;
    logic [7:0] w;
    get_byte(b);
    if (b[7:4] != 4'ha || b[3:1] == 3'h7) return;  // Own code only
    put(1'b1);
    if (b[0]) begin
      for (int i = 7; i >= 0; i--) put(!mem[b[3:1]][ptr[b[3:1]]][i]);
      put(1'b0);
    end else begin
      put(1'b0);
      get_byte(w);
      ptr[b[3:1]] = w;  // Single word-address byte
      put(1'b1);
      put(1'b0);
      get_byte(w);
      mem[b[3:1]][ptr[b[3:1]]] = w;
      put(1'b1);
      put(1'b0);
    end
  endtask

  // A data edge while SCL is high ends the frame; a falling one restarts it
  initial begin
    forever begin
      if (!restart) @(negedge i_sda iff i_scl);
      restart = 1'b0;
      fork
        frame();
        begin
          @(i_sda iff i_scl);
          restart = !i_sda;
        end
      join_any
      disable fork;
      o_sda_oe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verification/board_config_i2c_master_bench.sv
// Self-checking bench for the board configuration serial master
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module board_config_i2c_master_bench;
  typedef struct packed {
    logic       w;
    logic [2:0] dev;
    logic [7:0] word;
    logic [7:0] wdata;
    logic [7:0] rd;
    logic       nack;
  } bcim_row_type;

  logic sys_clk, link_clk, rst_n, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_nack;
  logic [2:0] cmd_dev;
  logic [7:0] cmd_word, cmd_wdata, rsp_rdata, planar;
  logic [3:0] strap, boot_cfg;
  logic planar_valid, cfg_valid, scl_o, scl_oe, sda_o, sda_oe, peer_oe, scl_wire, sda_wire;
  int fails = 0;
  int tests_run = 0;
  bcim_row_type rows [9];

  // Pull-ups hold both released wires high
  assign scl_wire = !scl_oe;
  assign sda_wire = !(sda_oe || peer_oe);

  // Short quarter bits keep a transfer near six thousand cycles
  board_config_i2c_master #(.STRAP_W(4), .QUARTER_CYCLES(5)) DUT (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_dev(cmd_dev),
    .i_cmd_word(cmd_word), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata), .o_rsp_nack(rsp_nack),
    .o_planar_info(planar), .o_planar_info_valid(planar_valid), .i_boot_strap(strap),
    .o_boot_cfg(boot_cfg), .o_boot_cfg_valid(cfg_valid), .o_scl_o(scl_o),
    .o_scl_oe(scl_oe), .i_sda_i(sda_wire), .o_sda_o(sda_o), .o_sda_oe(sda_oe));

  bcim_eeprom_model u_peer (.i_scl(scl_wire), .i_sda(sda_wire), .o_sda_oe(peer_oe));

  // Clocks: link clock offset so the two never line up
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = !sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #16 link_clk = !link_clk;
  end

  function automatic logic [7:0] fill(input logic [2:0] d, input logic [7:0] a);
    return a ^ {d, d, 2'h1};
  endfunction

  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // One command; valid stays up five busy cycles with other contents, which must be ignored
  task automatic run_cmd(input logic w, input logic [2:0] d, input logic [7:0] a,
                         input logic [7:0] wd);
    int n;
    {cmd_valid, cmd_write, cmd_dev, cmd_word, cmd_wdata} = {1'b1, w, d, a, wd};
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    if (n >= 100) begin
      fails++;
      close_out();
    end
    tick();
    cmd_dev = ~d;
    repeat (5) begin
      `CHECK("busy ready", 1'b0, cmd_ready)
      tick();
    end
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 12000) begin
      tick();
      n++;
    end
    if (n >= 12000) begin
      fails++;
      close_out();
    end
  endtask

  initial begin
    {rst_n, cmd_valid, cmd_write, cmd_dev, cmd_word, cmd_wdata} = '0;
    strap = 4'h9;
    rows = '{{1'b0, 3'h0, 8'h00, 8'h00, fill(3'h0, 8'h00), 1'b0},
             {1'b0, 3'h1, 8'hff, 8'h00, fill(3'h1, 8'hff), 1'b0},
             {1'b0, 3'h2, 8'h80, 8'h00, fill(3'h2, 8'h80), 1'b0},
             {1'b0, 3'h3, 8'h01, 8'h00, fill(3'h3, 8'h01), 1'b0},
             {1'b0, 3'h5, 8'h7f, 8'h00, fill(3'h5, 8'h7f), 1'b0},
             {1'b0, 3'h6, 8'hfe, 8'h00, fill(3'h6, 8'hfe), 1'b0},
             {1'b1, 3'h4, 8'hff, 8'ha5, 8'h00, 1'b0},
             {1'b0, 3'h4, 8'hff, 8'h00, 8'ha5, 1'b0},
             {1'b0, 3'h7, 8'h10, 8'h00, 8'ha5, 1'b1}};
    // Reset spans three link cycles so both domains see it
    repeat (3) @(posedge link_clk);
    tick();
    `CHECK("reset pins", 2'b00, {scl_oe, sda_oe})
    `CHECK("reset ready", 1'b0, cmd_ready)
    rst_n = 1'b1;
    repeat (3) tick();
    `CHECK("early cfg", 1'b0, cfg_valid)
    tick();
    `CHECK("cfg valid", 1'b1, cfg_valid)
    `CHECK("cfg value", 4'h9, boot_cfg)
    `CHECK("early ready", 1'b0, cmd_ready)
    tick();
    `CHECK("ready", 1'b1, cmd_ready)
    strap = 4'h6;
    // Every code, code 4 written then read back, word-address extremes, odd rows answer slowly
    for (int i = 0; i < 9; i++) begin
      u_peer.lag = (i % 2) * 200;
      run_cmd(rows[i].w, rows[i].dev, rows[i].word, rows[i].wdata);
      `CHECK("nack", rows[i].nack, rsp_nack)
      if (!rows[i].w) `CHECK("rdata", rows[i].rd, rsp_rdata)
    end
    // Planar byte kept from the good read, not the refused one
    tick();
    `CHECK("planar", 9'h1a5, {planar_valid, planar})
    `CHECK("cfg frozen", 4'h9, boot_cfg)
    // Second reset while idle: straps are taken afresh and the planar byte clears
    rst_n = 1'b0;
    repeat (3) @(posedge link_clk);
    tick();
    `CHECK("mid reset cfg", 5'h00, {cfg_valid, boot_cfg})
    `CHECK("mid reset planar", 9'h000, {planar_valid, planar})
    rst_n = 1'b1;
    repeat (5) tick();
    `CHECK("recaptured cfg", 5'h16, {cfg_valid, boot_cfg})
    `CHECK("ready again", 1'b1, cmd_ready)
    close_out();
  end
endmodule
`undef CHECK
`default_nettype wire
